/* File: logic/sl_pkg.sv */
package sl_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SEQ_CLK_HZ = 7_372_800;
  localparam int BAUD_CLK_HZ = 3_684_600;
  localparam int OVERSAMPLE = 16;
  localparam int NUM_LINES = 4;
  localparam int CONSOLE_LINE = 0;
  localparam int ADDR_W = 5;
  localparam int LINE_LSB = 3;
  localparam int REG_LSB = 1;

  // bus address setup before sync, rounded up to whole cycles
  localparam int ADDR_SETUP_NS = 150;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [1:0] REG_RX_CTRL = 2'h0;
  localparam logic [1:0] REG_RX_BUF = 2'h1;
  localparam logic [1:0] REG_TX_CTRL = 2'h2;
  localparam logic [1:0] REG_TX_BUF = 2'h3;

  localparam int RX_IE_BIT = 6;
  localparam int RX_RDY_BIT = 7;
  localparam int RX_FMT_LSB = 8;
  localparam int RX_TSEL_BIT = 15;
  localparam int TX_BRK_BIT = 0;
  localparam int TX_IE_BIT = 6;
  localparam int TX_RDY_BIT = 7;
  localparam int TX_RCE_BIT = 11;
  localparam int TX_RATE_LSB = 12;

  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [6:0] FMT_RST = 7'h00;
  localparam logic TX_RDY_RST = 1'b1;

  // line rates in tenths of a baud, so that 134.5 stays exact
  localparam int RATE_X10_T0 [16] = '{500, 500, 1100, 1345, 2000, 3000, 6000, 12000,
    12000, 10500, 24000, 24000, 48000, 72000, 96000, 384000};
  localparam int RATE_X10_T1 [16] = '{750, 750, 1100, 1345, 1500, 3000, 6000, 12000,
    12000, 20000, 24000, 24000, 48000, 18000, 96000, 192000};

  typedef enum logic [3:0] {
    CYC_WORD_READ = 4'b0001,
    CYC_WORD_WRITE = 4'b0010,
    CYC_LO_WRITE = 4'b0100,
    CYC_HI_WRITE = 4'b1000
  } cycle_t;

  localparam logic [2:0] HREG_ADDR = 3'h0;
  localparam logic [2:0] HREG_WDATA = 3'h1;
  localparam logic [2:0] HREG_CTRL = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_RDATA = 3'h4;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_BYTE_BIT = 2;
  localparam int CTRL_INIT_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  function automatic logic [15:0] baud_div(int rate_x10);
    return 16'((BAUD_CLK_HZ * 10) / (OVERSAMPLE * rate_x10));
  endfunction
endpackage

/* File: logic/sl_bus_if.sv */
`timescale 1ns/100ps
interface sl_bus_if;
  logic sync;
  logic din;
  logic dout;
  logic wtbt;
  logic init;
  logic [sl_pkg::ADDR_W-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rply;

  modport dev(input sync, input din, input dout, input wtbt, input init, input addr,
    input wdata, output rdata, output rply);
  modport host(output sync, output din, output dout, output wtbt, output init, output addr,
    output wdata, input rdata, input rply);
endinterface

/* File: logic/baud_table.sv */
`timescale 1ns/100ps
module baud_table (
  input wire logic [3:0] code_i,
  input wire logic table_i,
  output logic [15:0] div_o
);
  import sl_pkg::*;

  logic [15:0] div_t0 [16];
  logic [15:0] div_t1 [16];

  // divisors are elaboration constants, so no divider is built
  for (genvar g = 0; g < 16; g++) begin : g_rate
    assign div_t0[g] = baud_div(RATE_X10_T0[g]);
    assign div_t1[g] = baud_div(RATE_X10_T1[g]);
  end

  assign div_o = table_i ? div_t1[code_i] : div_t0[code_i];
endmodule

/* File: logic/serial_device.sv */
// Overview of operation
// - transmit interrupt enable bit six, init clears
// - ready bit seven raises interrupt with enable
// - rate changes only with rate-change bit eleven
// - four-bit rate code selects line baud rate
// - lines zero/two and three/one share tables
// - two fixed sixteen-entry baud rate tables
// - software right-justifies character in low byte
// - four lines, four registers each; console line has no break
// - receive format set only by high-byte write
// - configuration word split across both high bytes
// - baud generators run from dedicated baud clock
// - latch line and low address at sync
// - read strobe synchronised before access starts
// - word read, word, low, high writes
// - receive status: stored enable, live ready
// - receive status upper byte reads zero
// - master captures data on reply, drops strobe
// - reply after data, held until strobe removed
// - write data steered bytewise on eight-bit path
// - table select only lines zero, three; reads zero
`timescale 1ns/100ps
module serial_device (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic en_i,
  sl_bus_if.dev bus,
  input wire logic [sl_pkg::NUM_LINES-1:0] tx_accept_i,
  input wire logic [sl_pkg::NUM_LINES-1:0] rx_ready_i,
  input wire logic [sl_pkg::NUM_LINES-1:0][7:0] rx_char_i,
  output logic [7:0] tx_char_o,
  output logic [sl_pkg::NUM_LINES-1:0] tx_load_o,
  output logic [sl_pkg::NUM_LINES-1:0] brk_o,
  output logic [sl_pkg::NUM_LINES-1:0][6:0] fmt_o,
  output logic [sl_pkg::NUM_LINES-1:0][15:0] div_o,
  output logic [sl_pkg::NUM_LINES-1:0] tx_irq_o,
  output logic [sl_pkg::NUM_LINES-1:0] rx_irq_o
);
  import sl_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_REPLY = 5'b01000,
    ST_HOLD = 5'b10000
  } dev_st_t;

  typedef struct packed {
    dev_st_t st;
    logic [2:0] sync_p;
    logic [2:0] din_p;
    logic [2:0] dout_p;
    logic [2:0] init_p;
    logic sync_f;
    logic din_f;
    logic dout_f;
    logic init_f;
    logic [NUM_LINES-1:0][2:0] acc_p;
    logic [NUM_LINES-1:0][2:0] rxr_p;
    logic [NUM_LINES-1:0] acc_f;
    logic [NUM_LINES-1:0] rxr_f;
    cycle_t cyc;
    logic [1:0] line;
    logic [2:0] low;
    logic hi_phase;
    logic [NUM_LINES-1:0] tx_ie;
    logic [NUM_LINES-1:0] tx_rdy;
    logic [NUM_LINES-1:0] brk;
    logic [NUM_LINES-1:0] rx_irq_enable;
    logic [NUM_LINES-1:0][3:0] rate;
    logic [NUM_LINES-1:0][6:0] fmt;
    logic [1:0] tsel;
    logic [7:0] tx_char;
    logic [NUM_LINES-1:0] tx_load;
    logic [15:0] rdata;
    logic rply;
    logic [NUM_LINES-1:0] tx_irq;
    logic [NUM_LINES-1:0] rx_irq;
    logic [NUM_LINES-1:0][15:0] div;
  } dev_state_t;

  localparam dev_state_t RST = '{
    st: ST_IDLE,
    cyc: CYC_WORD_READ,
    tx_rdy: {NUM_LINES{TX_RDY_RST}},
    rate: {NUM_LINES{RATE_RST}},
    fmt: {NUM_LINES{FMT_RST}},
    default: '0
  };

  dev_state_t q;
  dev_state_t d;
  logic [NUM_LINES-1:0][15:0] div_w;

  // three-stage pin synchroniser; only stage two and three are compared
  function automatic logic [2:0] shift3(logic [2:0] p, logic pin);
    return {p[1:0], pin};
  endfunction

  function automatic logic settle(logic [2:0] p, logic f);
    return (p[1] == p[2]) ? p[2] : f;
  endfunction

  function automatic logic [7:0] lane(logic [15:0] w, logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // lines 0 and 2 follow table bit 0, lines 1 and 3 table bit 1
  function automatic logic pair_of(logic [1:0] ln);
    return ln[0];
  endfunction

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_baud
    baud_table u_table (
      .code_i(q.rate[g]),
      .table_i(q.tsel[pair_of(2'(g))]),
      .div_o(div_w[g])
    );
  end

  always_comb begin
    logic [15:0] rd;
    logic [7:0] b;
    rd = '0;
    b = lane(bus.wdata, q.hi_phase);
    d = q;
    d.sync_p = shift3(q.sync_p, bus.sync);
    d.din_p = shift3(q.din_p, bus.din);
    d.dout_p = shift3(q.dout_p, bus.dout);
    d.init_p = shift3(q.init_p, bus.init);
    d.sync_f = settle(q.sync_p, q.sync_f);
    d.din_f = settle(q.din_p, q.din_f);
    d.dout_f = settle(q.dout_p, q.dout_f);
    d.init_f = settle(q.init_p, q.init_f);
    for (int i = 0; i < NUM_LINES; i++) begin
      d.acc_p[i] = shift3(q.acc_p[i], tx_accept_i[i]);
      d.rxr_p[i] = shift3(q.rxr_p[i], rx_ready_i[i]);
      d.acc_f[i] = settle(q.acc_p[i], q.acc_f[i]);
      d.rxr_f[i] = settle(q.rxr_p[i], q.rxr_f[i]);
    end
    d.tx_load = '0;
    // divisors are for the uart's own baud clock, not for clock_i
    d.div = div_w;

    unique case (q.low[2:1])
      REG_RX_CTRL: begin
        rd[RX_IE_BIT] = q.rx_irq_enable[q.line];
        rd[RX_RDY_BIT] = q.rxr_f[q.line];
      end
      REG_RX_BUF: rd = {8'h00, rx_char_i[q.line]};
      REG_TX_CTRL: begin
        rd[TX_BRK_BIT] = q.brk[q.line];
        rd[TX_IE_BIT] = q.tx_ie[q.line];
        rd[TX_RDY_BIT] = q.tx_rdy[q.line];
      end
      REG_TX_BUF: rd = '0;
    endcase

    unique case (q.st)
      ST_IDLE: begin
        d.rply = 1'b0;
        if (d.sync_f && !q.sync_f) begin
          d.line = bus.addr[LINE_LSB +: 2];
          d.low = bus.addr[2:0];
          d.st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!q.sync_f) begin
          d.st = ST_IDLE;
        end else if (q.din_f) begin
          d.cyc = CYC_WORD_READ;
          d.rdata = rd;
          d.st = ST_REPLY;
        end else if (q.dout_f) begin
          if (!bus.wtbt) begin
            d.cyc = CYC_WORD_WRITE;
          end else if (q.low[0]) begin
            d.cyc = CYC_HI_WRITE;
          end else begin
            d.cyc = CYC_LO_WRITE;
          end
          d.hi_phase = bus.wtbt && q.low[0];
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // one byte per cycle over the internal path, low lane first
        unique case (q.low[2:1])
          REG_RX_CTRL: begin
            if (!q.hi_phase) begin
              d.rx_irq_enable[q.line] = b[RX_IE_BIT];
            end else if (q.cyc == CYC_HI_WRITE) begin
              d.fmt[q.line] = b[6:0];
              if (q.line == 2'h0 || q.line == 2'h3) begin
                d.tsel[pair_of(q.line)] = b[RX_TSEL_BIT - RX_FMT_LSB];
              end
            end
          end
          REG_RX_BUF: d.hi_phase = q.hi_phase;
          REG_TX_CTRL: begin
            if (!q.hi_phase) begin
              d.tx_ie[q.line] = b[TX_IE_BIT];
              if (q.line != 2'(CONSOLE_LINE)) begin
                d.brk[q.line] = b[TX_BRK_BIT];
              end
            end else if (b[TX_RCE_BIT - 8]) begin
              d.rate[q.line] = b[TX_RATE_LSB - 8 +: 4];
            end
          end
          REG_TX_BUF: begin
            if (!q.hi_phase) begin
              d.tx_char = b;
              d.tx_load[q.line] = 1'b1;
              d.tx_rdy[q.line] = 1'b0;
            end
          end
        endcase
        if (q.cyc == CYC_WORD_WRITE && !q.hi_phase) begin
          d.hi_phase = 1'b1;
        end else begin
          d.st = ST_REPLY;
        end
      end
      ST_REPLY: begin
        d.rply = 1'b1;
        d.st = ST_HOLD;
      end
      ST_HOLD: begin
        if (!q.din_f && !q.dout_f) begin
          d.rply = 1'b0;
          d.st = ST_IDLE;
        end
      end
    endcase

    // a fresh accept wins over a clear in the same cycle
    for (int i = 0; i < NUM_LINES; i++) begin
      if (d.acc_f[i] && !q.acc_f[i]) begin
        d.tx_rdy[i] = 1'b1;
      end
    end
    // init leaves rates, format and tables alone
    if (d.init_f) begin
      d.tx_ie = '0;
      d.rx_irq_enable = '0;
      d.brk = '0;
    end
    d.tx_irq = d.tx_ie & d.tx_rdy;
    d.rx_irq = d.rx_irq_enable & d.rxr_f;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= RST;
    end else if (en_i) begin
      q <= d;
    end
  end

  assign bus.rdata = q.rdata;
  assign bus.rply = q.rply;
  assign tx_char_o = q.tx_char;
  assign tx_load_o = q.tx_load;
  assign brk_o = q.brk;
  assign fmt_o = q.fmt;
  assign div_o = q.div;
  assign tx_irq_o = q.tx_irq;
  assign rx_irq_o = q.rx_irq;
endmodule

/* File: logic/bus_master.sv */
`timescale 1ns/100ps
module bus_master (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic en_i,
  sl_bus_if.host bus,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  import sl_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_SETUP = 4'b0010,
    H_STROBE = 4'b0100,
    H_WAIT = 4'b1000
  } host_st_t;

  typedef struct packed {
    host_st_t st;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wd;
    logic write;
    logic bytew;
    logic busy;
    logic done;
    logic [15:0] rbuf;
    logic [2:0] rply_p;
    logic rply_f;
    logic sync;
    logic din;
    logic dout;
    logic wtbt;
    logic init;
    logic [ADDR_W-1:0] baddr;
    logic [15:0] bwdata;
    logic [15:0] rdata;
  } host_state_t;

  localparam host_state_t RST = '{st: H_IDLE, default: '0};

  host_state_t q;
  host_state_t d;

  always_comb begin
    d = q;
    d.rply_p = {q.rply_p[1:0], bus.rply};
    d.rply_f = (q.rply_p[1] == q.rply_p[2]) ? q.rply_p[2] : q.rply_f;
    if (rd_i) begin
      unique case (addr_i)
        HREG_ADDR: d.rdata = 16'(q.addr);
        HREG_WDATA: d.rdata = q.wd;
        HREG_CTRL: d.rdata = 16'({q.init, q.bytew, q.write, 1'b0});
        HREG_STATUS: d.rdata = 16'({q.done, q.busy});
        HREG_RDATA: d.rdata = q.rbuf;
        default: d.rdata = '0;
      endcase
    end
    // orders are ignored while a bus cycle is under way
    if (wr_i && !q.busy) begin
      unique case (addr_i)
        HREG_ADDR: d.addr = wdata_i[ADDR_W-1:0];
        HREG_WDATA: d.wd = wdata_i;
        HREG_CTRL: begin
          d.write = wdata_i[CTRL_WRITE_BIT];
          d.bytew = wdata_i[CTRL_BYTE_BIT];
          d.init = wdata_i[CTRL_INIT_BIT];
          if (wdata_i[CTRL_GO_BIT]) begin
            d.busy = 1'b1;
            d.done = 1'b0;
            d.baddr = q.addr;
            d.bwdata = q.wd;
            d.wtbt = wdata_i[CTRL_BYTE_BIT] && wdata_i[CTRL_WRITE_BIT];
            d.cnt = 4'(ADDR_SETUP_CYC - 1);
            d.st = H_SETUP;
          end
        end
        default: d.addr = q.addr;
      endcase
    end
    unique case (q.st)
      H_IDLE: d.sync = 1'b0;
      H_SETUP: begin
        if (q.cnt == 4'h0) begin
          d.sync = 1'b1;
          d.st = H_STROBE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      H_STROBE: begin
        d.din = !q.write;
        d.dout = q.write;
        if (q.rply_f) begin
          if (!q.write) begin
            d.rbuf = bus.rdata;
          end
          d.din = 1'b0;
          d.dout = 1'b0;
          d.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (!q.rply_f) begin
          d.sync = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= RST;
    end else if (en_i) begin
      q <= d;
    end
  end

  assign bus.sync = q.sync;
  assign bus.din = q.din;
  assign bus.dout = q.dout;
  assign bus.wtbt = q.wtbt;
  assign bus.init = q.init;
  assign bus.addr = q.baddr;
  assign bus.wdata = q.bwdata;
  assign rdata_o = q.rdata;
endmodule

/* File: tb/sl_bus_chk.sv */
`timescale 1ns/100ps
module sl_bus_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic sync,
  input wire logic din,
  input wire logic dout,
  input wire logic init,
  input wire logic [sl_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] rdata,
  input wire logic rply
);
  import sl_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  reply_cause_a: assert property ($rose(rply) |-> sync && (din || dout))
    else $error("reply rose without an address strobe and a data strobe");
  reply_hold_a: assert property (rply && (din || dout) |=> rply)
    else $error("reply dropped while the strobe was still up");
  reply_release_a: assert property ($fell(din) || $fell(dout) |-> ##[1:8] !rply)
    else $error("reply not released after the strobe dropped");
  // the strobe passes a synchroniser, so no reply can come in the first three cycles
  read_latency_a: assert property ($rose(din) |-> !rply [*3] ##[1:9] rply)
    else $error("read reply too early or too late");
  write_latency_a: assert property ($rose(dout) |-> !rply [*3] ##[1:12] rply)
    else $error("write reply too early or too late");
  read_data_a: assert property (rply && din |-> $stable(rdata))
    else $error("read data changed while the reply was up");
  rx_upper_a: assert property (rply && din && addr[2:1] == REG_RX_CTRL
    |-> rdata[15:8] == 8'h00)
    else $error("receive status upper byte not zero");
  host_wait_a: assert property (din && !rply |=> din)
    else $error("read strobe dropped before the reply");
  host_release_a: assert property (rply && din |-> ##[0:6] !din)
    else $error("read strobe held too long after the reply");
  strobe_order_a: assert property ($rose(din) || $rose(dout) |-> sync)
    else $error("data strobe without address strobe");

  cover property ($rose(rply) && din);
  cover property ($rose(rply) && dout);
  cover property ($rose(init));
endmodule

/* File: tb/serial_line_tx_config_bench.sv */
`timescale 1ns/100ps
module serial_line_tx_config_bench;
  import sl_pkg::*;
  localparam logic [3:0] RD = 4'h1;
  localparam logic [3:0] WR = 4'h3;
  localparam logic [3:0] BW = 4'h7;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [3:0] tx_accept_i = 4'hf;
  logic [3:0] rx_ready_i = 4'h0;
  logic [3:0][7:0] rx_char_i = 32'h44332211;
  logic [7:0] tx_char_o;
  logic [3:0] tx_load_o, brk_o, tx_irq_o, rx_irq_o;
  logic [3:0][6:0] fmt_o;
  logic [3:0][15:0] div_o;
  logic [3:0] load_seen = 4'h0;
  logic [7:0] load_chr = 8'h00;
  logic [15:0] r;
  logic dev_en = 1'b1;
  int fail_count = 0;
  int n_tests = 0;

  sl_bus_if bus();
  bus_master i_bus_master(.clock_i(clock_i), .nrst_i(nrst_i), .en_i(1'b1), .bus(bus),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  serial_device i_serial_device(.clock_i(clock_i), .nrst_i(nrst_i), .en_i(dev_en), .bus(bus),
    .tx_accept_i(tx_accept_i), .rx_ready_i(rx_ready_i), .rx_char_i(rx_char_i),
    .tx_char_o(tx_char_o), .tx_load_o(tx_load_o), .brk_o(brk_o), .fmt_o(fmt_o),
    .div_o(div_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
  sl_bus_chk i_sl_bus_chk(.clock_i(clock_i), .nrst_i(nrst_i), .sync(bus.sync), .din(bus.din),
    .dout(bus.dout), .init(bus.init), .addr(bus.addr), .rdata(bus.rdata), .rply(bus.rply));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // load pulses last one cycle, so keep the latest one for later checks
  always @(posedge clock_i) begin
    if (|tx_load_o) begin
      load_seen <= tx_load_o;
      load_chr <= tx_char_o;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] xd(input int rate_x10);
    return 16'((BAUD_CLK_HZ * 10) / (OVERSAMPLE * rate_x10));
  endfunction

  function automatic logic [4:0] ad(input int ln, input logic [1:0] rg, input logic hi);
    return {2'(ln), rg, hi};
  endfunction

  task automatic hw(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic hr(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // one bus cycle through the host registers; readback lands in r
  task automatic op(input logic [4:0] a, input logic [15:0] d, input logic [3:0] c);
    int n;
    logic [15:0] s;
    hw(HREG_ADDR, {11'h000, a});
    hw(HREG_WDATA, d);
    hw(HREG_CTRL, {12'h000, c});
    n = 0;
    s = 16'h0000;
    while (s[STAT_DONE_BIT] !== 1'b1 && n < 40) begin
      hr(HREG_STATUS, s);
      n++;
    end
    chk(s & 16'h0002, 16'h0002);
    hr(HREG_RDATA, r);
    repeat (2) @(posedge clock_i);
  endtask

  task automatic bus_init;
    hw(HREG_CTRL, 16'h0008);
    repeat (10) @(posedge clock_i);
    hw(HREG_CTRL, 16'h0000);
    repeat (6) @(posedge clock_i);
  endtask

  task automatic s_reset;
    for (int i = 0; i < 4; i++) chk(div_o[i], xd(RATE_X10_T0[0]));
    op(ad(1, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0080);
    chk({12'h000, tx_irq_o}, 16'h0000);
  endtask

  task automatic s_irq;
    op(ad(1, REG_TX_CTRL, 0), 16'h0041, WR);
    chk({12'h000, tx_irq_o}, 16'h0002);
    chk({12'h000, brk_o}, 16'h0002);
    op(ad(1, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h00c1);
    bus_init();
    op(ad(1, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0080);
    chk({12'h000, tx_irq_o}, 16'h0000);
    chk({12'h000, brk_o}, 16'h0000);
  endtask

  task automatic s_rate;
    op(ad(2, REG_TX_CTRL, 0), 16'hf800, WR);
    chk(div_o[2], xd(RATE_X10_T0[15]));
    op(ad(2, REG_TX_CTRL, 0), 16'h3000, WR);
    chk(div_o[2], xd(RATE_X10_T0[15]));
    bus_init();
    chk(div_o[2], xd(RATE_X10_T0[15]));
    op(ad(0, REG_RX_CTRL, 1), 16'h8000, BW);
    chk(div_o[2], xd(RATE_X10_T1[15]));
    chk(div_o[0], xd(RATE_X10_T1[0]));
    chk(div_o[1], xd(RATE_X10_T0[0]));
    op(ad(2, REG_RX_CTRL, 1), 16'h0000, BW);
    chk(div_o[2], xd(RATE_X10_T1[15]));
    op(ad(0, REG_RX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      op(ad(3, REG_RX_CTRL, 1), {t[0], 15'h0000}, BW);
      for (int k = 0; k < 16; k++) begin
        op(ad(1, REG_TX_CTRL, 0), {k[3:0], 12'h800}, WR);
        chk(div_o[1], xd(t ? RATE_X10_T1[k] : RATE_X10_T0[k]));
      end
    end
  endtask

  task automatic s_tx;
    op(ad(3, REG_TX_BUF, 0), 16'h005a, WR);
    chk({12'h000, load_seen}, 16'h0008);
    chk({8'h00, load_chr}, 16'h005a);
    op(ad(3, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0000);
    op(ad(3, REG_TX_BUF, 0), 16'h0000, RD);
    chk(r, 16'h0000);
    // a frozen device must miss a whole accept pulse
    dev_en <= 1'b0;
    tx_accept_i[3] <= 1'b0;
    repeat (6) @(posedge clock_i);
    tx_accept_i[3] <= 1'b1;
    repeat (6) @(posedge clock_i);
    dev_en <= 1'b1;
    repeat (6) @(posedge clock_i);
    op(ad(3, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0000);
    tx_accept_i[3] <= 1'b0;
    repeat (6) @(posedge clock_i);
    tx_accept_i[3] <= 1'b1;
    repeat (6) @(posedge clock_i);
    op(ad(3, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h0080);
  endtask

  task automatic s_rx;
    rx_ready_i[1] <= 1'b1;
    op(ad(1, REG_RX_CTRL, 0), 16'hff40, WR);
    op(ad(1, REG_RX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h00c0);
    chk({9'h000, fmt_o[1]}, 16'h0000);
    chk({12'h000, rx_irq_o}, 16'h0002);
    op(ad(1, REG_RX_CTRL, 1), 16'h1300, BW);
    chk({9'h000, fmt_o[1]}, 16'h0013);
    op(ad(2, REG_RX_BUF, 0), 16'h0000, RD);
    chk(r, 16'h0033);
    op(ad(0, REG_TX_CTRL, 0), 16'hff41, BW);
    op(ad(0, REG_TX_CTRL, 0), 16'h0000, RD);
    chk(r, 16'h00c0);
    chk({12'h000, brk_o}, 16'h0000);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    s_reset();
    s_irq();
    s_rate();
    s_tx();
    s_rx();
    stop_test();
  end

  // about fifty bus cycles of some forty clocks each are expected
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    stop_test();
  end
endmodule
